/* rtl/pab_cfg.svh */
`ifndef PAB_CFG_SVH
`define PAB_CFG_SVH
// Address map
`define PAB_BASE_DEFAULT 7'h5c
`define PAB_GLOBAL_ADDR 7'h5b
`define PAB_ARA_ADDR 7'h0c
`define PAB_HIGH_STEP 4'h3
// Command codes of interest to the busy logic
`define PAB_CMD_STATUS 8'he5
`define PAB_CMD_CLEAR 8'h03
`define PAB_CMD_RESTORE 8'h16
`define PAB_CMD_LOG_CLEAR 8'hec
`define PAB_CMD_LOG_STORE 8'hea
`define PAB_CMD_OCAL 8'h38
`define PAB_CMD_ICAL 8'he8
`define PAB_CMD_DPLUS_A 8'he0
`define PAB_CMD_DPLUS_B 8'he1
`define PAB_CMD_OCL 8'h46
`define PAB_CMD_UCL 8'h4b
`define PAB_CMD_OVL 8'h40
`define PAB_CMD_UVL 8'h44
`define PAB_CMD_CONFIG 8'hd0
`define PAB_CMD_RISE 8'h61
`define PAB_CMD_DAC 8'he2
// Status bit positions
`define PAB_STAT_NOTBUSY 6
// Busy times in microseconds, system clock in MHz
`define PAB_CLK_MHZ 40
`define PAB_T_RESTORE_US 30000
`define PAB_T_LOG_CLEAR_US 175000
`define PAB_T_LOG_STORE_US 20000
`define PAB_T_CAL_US 500
`define PAB_T_RAM_US 50
`define PAB_T_FLAG_CLR_US 500
`endif

/* rtl/pab_pkg.sv */
package pab_pkg;
   typedef enum logic [4:0] {
      LK_IDLE = 5'h01,
      LK_ADDR = 5'h02,
      LK_CMD = 5'h04,
      LK_DATA = 5'h08,
      LK_SKIP = 5'h10
   } pab_link_t;
   typedef enum logic [2:0] {
      BS_IDLE = 3'h1,
      BS_ARMED = 3'h2,
      BS_RUN = 3'h4
   } pab_busy_t;
endpackage

/* rtl/pab_cross_if.sv */
`timescale 1ns/10ps
// Events and levels between the link domain and the system domain
interface pab_cross_if;
   logic start_tgl;
   logic stop_tgl;
   logic cmd_tgl;
   logic [7:0] cmd_code;
   logic cmd_write;
   logic busy;
   logic [7:0] status_byte;
   logic busy_fault_tgl;
   modport link (output start_tgl, stop_tgl, cmd_tgl, cmd_code, cmd_write,
      busy_fault_tgl, input busy, status_byte);
   modport core (input start_tgl, stop_tgl, cmd_tgl, cmd_code, cmd_write,
      busy_fault_tgl, output busy, status_byte);
endinterface

/* rtl/pab_link.sv */
`timescale 1ns/10ps
`include "pab_cfg.svh"
// Link-domain front end, clocked by the bus clock line and, for start/stop detection, by data line edges.
module pab_link import pab_pkg::*; #(
   parameter int AW = 7
) (
   input wire logic scl,
   input wire logic rst_n,
   input wire logic sda_i,
   input wire logic [AW-1:0] own_addr,
   output logic sda_oe_n,
   pab_cross_if.link x
);
   // ------------------------------------------------------------
   // Start/stop detection on data edges while the clock is high
   // ------------------------------------------------------------
   logic start_seen;
   logic stop_seen;
   always_ff @(negedge sda_i or negedge rst_n) begin
      if (!rst_n) begin
         start_seen <= 1'b0;
      end else if (scl) begin
         start_seen <= ~start_seen;
      end
   end
   always_ff @(posedge sda_i or negedge rst_n) begin
      if (!rst_n) begin
         stop_seen <= 1'b0;
      end else if (scl) begin
         stop_seen <= ~stop_seen;
      end
   end
   // ------------------------------------------------------------
   // Bit engine
   // ------------------------------------------------------------
   typedef struct packed {
      pab_link_t st;
      logic [3:0] bit_cnt;
      logic [7:0] sh;
      logic ack;
      logic rd;
      logic refuse;
      logic start_ack;
      logic stop_ack;
      logic cmd_tgl;
      logic [7:0] cmd_code;
      logic cmd_write;
      logic fault_tgl;
      logic [7:0] tx;
   } lk_t;
   lk_t r;
   lk_t n;
   logic [AW-1:0] a7;
   assign a7 = n.sh[7:1];
   always_comb begin
      n = r;
      n.bit_cnt = r.bit_cnt + 4'h1;
      n.sh = {r.sh[6:0], sda_i};
      if (r.start_ack != start_seen) begin
         // The clock stands still after a stop, so a stop may still be
         // pending here; absorb it so it cannot end the new frame
         n.start_ack = start_seen;
         n.stop_ack = stop_seen;
         n.st = LK_ADDR;
         n.bit_cnt = 4'h1;
         n.sh = {7'h00, sda_i};
         n.ack = 1'b0;
         n.rd = 1'b0;
      end else if (r.stop_ack != stop_seen) begin
         n.stop_ack = stop_seen;
         n.st = LK_IDLE;
         n.ack = 1'b0;
      end else if (r.bit_cnt == 4'h7) begin
         n.ack = 1'b0;
         unique case (r.st)
            LK_ADDR: begin
               // Own, global and alert response addresses
               if (a7 == own_addr || a7 == `PAB_GLOBAL_ADDR ||
                   a7 == `PAB_ARA_ADDR) begin
                  n.ack = 1'b1;
                  n.rd = n.sh[0];
                  n.tx = x.status_byte;
                  n.st = n.sh[0] ? LK_DATA : LK_CMD;
               end else begin
                  n.st = LK_SKIP;
               end
            end
            LK_CMD: begin
               n.cmd_code = n.sh;
               // Status read never refused nor faulted
               n.refuse = x.busy && n.sh != `PAB_CMD_STATUS;
               if (n.refuse) begin
                  n.fault_tgl = ~r.fault_tgl;
                  n.st = LK_SKIP;
               end else begin
                  n.ack = 1'b1;
                  n.cmd_write = 1'b1;
                  n.cmd_tgl = ~r.cmd_tgl;
                  n.st = LK_DATA;
               end
            end
            LK_DATA: n.ack = ~r.rd;
            default: ;
         endcase
      end else if (r.bit_cnt == 4'h8) begin
         // Acknowledge bit; a host nack ends a read so the line is freed
         n.bit_cnt = 4'h0;
         n.ack = 1'b0;
         if (r.rd && r.st == LK_DATA && sda_i) begin
            n.st = LK_SKIP;
         end
      end
   end
   always_ff @(posedge scl) begin
      if (!rst_n) begin
         r <= '{st: LK_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end
   // Drive on falling edge so data is stable while clock is high
   logic drive;
   always_ff @(negedge scl) begin
      if (!rst_n) begin
         drive <= 1'b0;
      end else begin
         drive <= r.ack || (r.rd && r.st == LK_DATA && r.bit_cnt < 4'h8 &&
                  !r.tx[3'(4'h7 - r.bit_cnt)]);
      end
   end
   assign sda_oe_n = ~drive;
   // Conditions cross straight from their flops: no clock edge follows a stop
   assign x.start_tgl = start_seen;
   assign x.stop_tgl = stop_seen;
   assign x.cmd_tgl = r.cmd_tgl;
   assign x.cmd_code = r.cmd_code;
   assign x.cmd_write = r.cmd_write;
   assign x.busy_fault_tgl = r.fault_tgl;
endmodule

/* rtl/pab_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser for levels and toggles
module pab_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk) begin
      meta <= d;
      q <= meta;
   end
endmodule

/* rtl/pab_top.sv */
`timescale 1ns/10ps
`include "pab_cfg.svh"
module pab_top import pab_pkg::*; #(
   parameter int T_RESTORE = `PAB_T_RESTORE_US * `PAB_CLK_MHZ,
   parameter int T_LOG_CLEAR = `PAB_T_LOG_CLEAR_US * `PAB_CLK_MHZ,
   parameter int T_LOG_STORE = `PAB_T_LOG_STORE_US * `PAB_CLK_MHZ,
   parameter int T_FLAG_CLR = `PAB_T_FLAG_CLR_US * `PAB_CLK_MHZ,
   parameter int T_CAL = `PAB_T_CAL_US * `PAB_CLK_MHZ - 1,
   parameter int T_RAM = `PAB_T_RAM_US * `PAB_CLK_MHZ - 1
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic [1:0] I_ADDR_SELECT_LOW,
   input wire logic [1:0] I_ADDR_SELECT_HIGH,
   input wire logic I_BASE_WE,
   input wire logic [6:0] I_BASE_ADDR,
   input wire logic I_LONG_TIMEOUT,
   input wire logic I_FAULT_CLEAR,
   input wire logic I_LOG_EVENT,
   output logic O_SDA,
   output logic O_SDA_OE_N,
   output logic O_ALERT_OUT_N,
   output logic O_BUSY_FAULT,
   output logic O_BUSY,
   output logic [7:0] O_STATUS,
   output logic [7:0] O_CMD_CODE,
   output logic O_CMD_VALID,
   output logic O_FLAG_CLR_PEND,
   output logic O_LONG_TIMEOUT
);
   // ------------------------------------------------------------
   // Strap decoding and crossings
   // ------------------------------------------------------------
   // Strap code 2'b00 low, 2'b01 open, 2'b10 high
   logic [3:0] sel_s;
   pab_sync #(.W(4)) u_sel (
      .clk(I_CLK),
      .d({I_ADDR_SELECT_HIGH, I_ADDR_SELECT_LOW}),
      .q(sel_s)
   );
   pab_cross_if xi();
   logic [3:0] tg_s;
   pab_sync #(.W(4)) u_tg (
      .clk(I_CLK),
      .d({xi.start_tgl, xi.stop_tgl, xi.cmd_tgl, xi.busy_fault_tgl}),
      .q(tg_s)
   );
   logic sda_oe_n_lk;
   logic [1:0] oe_s;
   logic [6:0] own_lk;
   typedef struct packed {
      pab_busy_t bst;
      logic [3:0] tg_d;
      logic [6:0] base;
      logic [6:0] own;
      logic [31:0] cnt;
      logic [31:0] load;
      logic [31:0] clr_cnt;
      logic [7:0] code;
      logic fault;
      logic alert;
      logic cmd_valid;
      logic long_to;
   } st_t;
   st_t r;
   st_t n;
   logic [3:0] n_off;
   logic ev_start;
   logic ev_stop;
   logic ev_cmd;
   logic ev_fault;
   assign ev_start = tg_s[3] ^ r.tg_d[3];
   assign ev_stop = tg_s[2] ^ r.tg_d[2];
   assign ev_cmd = tg_s[1] ^ r.tg_d[1];
   assign ev_fault = tg_s[0] ^ r.tg_d[0];
   assign n_off = `PAB_HIGH_STEP * {2'h0, sel_s[3:2]} + {2'h0, sel_s[1:0]};
   // ------------------------------------------------------------
   // Busy engine
   // ------------------------------------------------------------
   function automatic logic [31:0] busy_time(input logic [7:0] c);
      logic [31:0] t;
      t = 32'h0;
      unique case (c)
         `PAB_CMD_RESTORE: t = 32'(T_RESTORE);
         `PAB_CMD_LOG_CLEAR: t = 32'(T_LOG_CLEAR);
         `PAB_CMD_LOG_STORE: t = 32'(T_LOG_STORE);
         `PAB_CMD_OCAL, `PAB_CMD_ICAL: t = 32'(T_CAL);
         `PAB_CMD_DPLUS_A, `PAB_CMD_DPLUS_B, `PAB_CMD_OCL, `PAB_CMD_UCL,
         `PAB_CMD_OVL, `PAB_CMD_UVL, `PAB_CMD_CONFIG, `PAB_CMD_RISE,
         `PAB_CMD_DAC: t = 32'(T_RAM);
         default: t = 32'h0;
      endcase
      return t;
   endfunction
   always_comb begin
      n = r;
      n.tg_d = tg_s;
      n.cmd_valid = ev_cmd;
      n.long_to = I_LONG_TIMEOUT;
      if (I_BASE_WE) begin
         n.base = I_BASE_ADDR;
      end
      n.own = r.base + {3'h0, n_off};
      if (r.clr_cnt != 32'h0) begin
         n.clr_cnt = r.clr_cnt - 32'h1;
      end
      if (ev_cmd) begin
         n.code = xi.cmd_code;
         if (xi.cmd_code == `PAB_CMD_CLEAR) begin
            n.clr_cnt = 32'(T_FLAG_CLR);
         end
      end
      unique case (r.bst)
         BS_IDLE: begin
            if (ev_cmd && busy_time(xi.cmd_code) != 32'h0) begin
               n.load = busy_time(xi.cmd_code);
               n.bst = BS_ARMED;
            end else if (I_LOG_EVENT) begin
               n.cnt = 32'(T_LOG_STORE);
               n.bst = BS_RUN;
            end
         end
         BS_ARMED: begin
            // Timing starts at the stop that ends the command
            if (ev_stop) begin
               n.cnt = r.load;
               n.bst = BS_RUN;
            end else if (ev_start) begin
               n.bst = BS_IDLE;
            end
         end
         BS_RUN: begin
            n.cnt = r.cnt - 32'h1;
            if (r.cnt == 32'h1) begin
               n.bst = BS_IDLE;
            end
         end
      endcase
      // Sticky: a new fault wins over a clear in the same cycle
      if (I_FAULT_CLEAR) begin
         n.fault = 1'b0;
      end
      if (ev_fault) begin
         n.fault = 1'b1;
      end
      n.alert = n.fault;
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         r <= '{bst: BS_IDLE, base: `PAB_BASE_DEFAULT, default: '0};
      end else begin
         r <= n;
      end
   end
   logic busy_lvl;
   logic [7:0] status_val;
   logic [8:0] bsy_lk;
   assign busy_lvl = r.bst != BS_IDLE;
   assign status_val = {1'b0, ~busy_lvl, 6'h00};
   // Busy and status enter the link domain through two flops
   pab_sync #(.W(9)) u_bsy (
      .clk(I_SCL),
      .d({busy_lvl, status_val}),
      .q(bsy_lk)
   );
   assign xi.busy = bsy_lk[8];
   assign xi.status_byte = bsy_lk[7:0];
   // ------------------------------------------------------------
   // Link front end, own address crossed as a slow quasi-static word
   // ------------------------------------------------------------
   pab_sync #(.W(7)) u_own (
      .clk(I_SCL),
      .d(r.own),
      .q(own_lk)
   );
   pab_link u_link (
      .scl(I_SCL),
      .rst_n(I_RST_N),
      .sda_i(I_SDA),
      .own_addr(own_lk),
      .sda_oe_n(sda_oe_n_lk),
      .x(xi.link)
   );
   pab_sync #(.W(2)) u_oe (
      .clk(I_CLK),
      .d({sda_oe_n_lk, 1'b0}),
      .q(oe_s)
   );
   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_SDA <= 1'b0;
         O_SDA_OE_N <= 1'b1;
         O_ALERT_OUT_N <= 1'b1;
         O_BUSY_FAULT <= 1'b0;
         O_BUSY <= 1'b0;
         O_STATUS <= 8'h40;
         O_CMD_CODE <= 8'h00;
         O_CMD_VALID <= 1'b0;
         O_FLAG_CLR_PEND <= 1'b0;
         O_LONG_TIMEOUT <= 1'b0;
      end else begin
         O_SDA <= oe_s[0];
         O_SDA_OE_N <= oe_s[1];
         O_ALERT_OUT_N <= ~r.alert;
         O_BUSY_FAULT <= r.fault;
         O_BUSY <= busy_lvl;
         O_STATUS <= status_val;
         O_CMD_CODE <= r.code;
         O_CMD_VALID <= r.cmd_valid;
         O_FLAG_CLR_PEND <= r.clr_cnt != 32'h0;
         O_LONG_TIMEOUT <= r.long_to;
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_fault_sticky: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      r.fault && !I_FAULT_CLEAR |=> r.fault)
      else $error("busy fault dropped without clear");
   a_fault_alert: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      r.fault |=> !O_ALERT_OUT_N)
      else $error("alert not low after fault");
   a_status_bit: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      busy_lvl |=> !O_STATUS[`PAB_STAT_NOTBUSY])
      else $error("status busy bit wrong");
   a_armed_stop: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      r.bst == BS_ARMED && ev_stop |=> r.bst == BS_RUN)
      else $error("busy not started at stop");
   a_base_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      I_BASE_WE |=> r.base == $past(I_BASE_ADDR))
      else $error("base address not stored");
   a_offset_max: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      sel_s == 4'ha |-> n_off == 4'h8)
      else $error("strap offset wrong");
   a_run_ends: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      r.bst == BS_RUN && r.cnt == 32'h1 |=> r.bst == BS_IDLE)
      else $error("busy interval overran");
   a_clear_pend: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      ev_cmd && xi.cmd_code == `PAB_CMD_CLEAR |=> ##1 O_FLAG_CLR_PEND)
      else $error("flag clear not pending");
   c_busy_run: cover property (@(posedge I_CLK) r.bst == BS_RUN);
   c_fault: cover property (@(posedge I_CLK) ev_fault);
   c_clear: cover property (@(posedge I_CLK) r.fault ##1 !r.fault);
endmodule

/* testbench/pab_host.sv */
`timescale 1ns/10ps
// ---------------------------------------------
// Bus host model, SCL stands high between frames
// ---------------------------------------------
module pab_host (
   output logic scl,
   output logic sda,
   input wire logic sda_line
);
   localparam time H = 24;
   // Long low phase: the target's drive lags by a few system clocks
   localparam time L = 192;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic idle_clk(input int n);
      for (int i = 0; i < n; i++) begin
         #H scl = 1'b0;
         #H scl = 1'b1;
      end
   endtask
   // Also used as repeated start for a combined read
   task automatic start();
      // Long low phase lets the target release its ack first
      sda = 1'b1;
      #L scl = 1'b1;
      #H sda = 1'b0;
      #H scl = 1'b0;
   endtask
   task automatic stop();
      sda = 1'b0;
      #H scl = 1'b1;
      #H sda = 1'b1;
      #H;
   endtask
   task automatic bit_io(input logic b, input time lo, output logic r);
      sda = b;
      #lo scl = 1'b1;
      r = sda_line;
      #H scl = 1'b0;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], (i == 7) ? L : H, r);
      end
      bit_io(1'b1, L, r);
      ack = ~r;
   endtask
   task automatic rd_byte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, L, d[i]);
      end
      bit_io(1'b1, L, r);
   endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
`include "pab_cfg.svh"
module testbench;
   localparam int TR = 800;
   localparam int TE = 1000;
   localparam int TS = 300;
   localparam int TF = 200;
   localparam int TC = 250;
   localparam int TM = 150;
   logic clk, rst_n, scl, sda_h, base_we, long_to, flt_clr, log_ev;
   logic [1:0] sel_lo, sel_hi;
   logic [6:0] base, own;
   logic sda_o, sda_oe_n, alert_n, fault, busy, pend, cmd_valid, long_o;
   logic [7:0] status, cmd_code;
   // Pull-up line: any party enabling its driver pulls it low
   wire logic sda_line = sda_h & (sda_oe_n | sda_o);
   int err_count = 0;
   int check_count = 0;
   int valid_cnt = 0;
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) valid_cnt++;
   end

   pab_top #(.T_RESTORE(TR), .T_LOG_CLEAR(TE), .T_LOG_STORE(TS),
      .T_FLAG_CLR(TF), .T_CAL(TC), .T_RAM(TM)) dut_u (
      .I_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda_line),
      .I_ADDR_SELECT_LOW(sel_lo), .I_ADDR_SELECT_HIGH(sel_hi),
      .I_BASE_WE(base_we), .I_BASE_ADDR(base), .I_LONG_TIMEOUT(long_to),
      .I_FAULT_CLEAR(flt_clr), .I_LOG_EVENT(log_ev), .O_SDA(sda_o),
      .O_SDA_OE_N(sda_oe_n), .O_ALERT_OUT_N(alert_n), .O_BUSY_FAULT(fault),
      .O_BUSY(busy), .O_STATUS(status), .O_CMD_CODE(cmd_code),
      .O_CMD_VALID(cmd_valid), .O_FLAG_CLR_PEND(pend),
      .O_LONG_TIMEOUT(long_o));
   pab_host host_u (.scl(scl), .sda(sda_h), .sda_line(sda_line));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // 0 base write, 1 fault clear, 2 log event
   task automatic pulse(input int w);
      @(posedge clk);
      if (w == 0) base_we <= 1'b1;
      else if (w == 1) flt_clr <= 1'b1;
      else log_ev <= 1'b1;
      @(posedge clk);
      base_we <= 1'b0;
      flt_clr <= 1'b0;
      log_ev <= 1'b0;
      cyc(4);
   endtask
   task automatic send(input logic [6:0] a, input int n,
         input logic [7:0] c, output logic aa, output logic ca);
      logic k;
      ca = 1'b0;
      host_u.start();
      host_u.wr_byte({a, 1'b0}, aa);
      if (n > 0) host_u.wr_byte(c, ca);
      for (int i = 1; i < n; i++) host_u.wr_byte(8'h5a, k);
      host_u.stop();
   endtask
   task automatic rd_status(output logic [7:0] d, output logic ca);
      logic k;
      host_u.start();
      host_u.wr_byte({own, 1'b0}, k);
      host_u.wr_byte(`PAB_CMD_STATUS, ca);
      host_u.start();
      host_u.wr_byte({own, 1'b1}, k);
      host_u.rd_byte(d);
      host_u.stop();
   endtask
   // Waits for busy to rise, then counts its length
   task automatic busy_len(output int len);
      int w = 0;
      len = 0;
      while (busy !== 1'b1 && w < 60) begin
         @(posedge clk);
         w++;
      end
      while (busy === 1'b1 && len < 3000) begin
         @(posedge clk);
         len++;
      end
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_addr();
      logic aa, ca;
      for (int h = 0; h < 3; h++) begin
         for (int l = 0; l < 3; l++) begin
            @(posedge clk);
            sel_hi <= 2'(h);
            sel_lo <= 2'(l);
            cyc(8);
            send(7'h5c + 7'(3 * h + l), 0, 8'h00, aa, ca);
            check(aa, 1'b1);
            send(7'h65 + 7'(3 * h + l), 0, 8'h00, aa, ca);
            check(aa, 1'b0);
         end
      end
      check(sda_o, 1'b0);
      base <= 7'h20;
      pulse(0);
      own = 7'h28;
      send(own, 0, 8'h00, aa, ca);
      check(aa, 1'b1);
      send(7'h64, 0, 8'h00, aa, ca);
      check(aa, 1'b0);
      send(`PAB_GLOBAL_ADDR, 0, 8'h00, aa, ca);
      check(aa, 1'b1);
      send(`PAB_ARA_ADDR, 0, 8'h00, aa, ca);
      check(aa, 1'b1);
   endtask
   task automatic t_busy();
      logic aa, ca;
      int len;
      int v0;
      logic [7:0] cs [14] = '{`PAB_CMD_RESTORE, `PAB_CMD_LOG_CLEAR,
         `PAB_CMD_LOG_STORE, `PAB_CMD_OCAL, `PAB_CMD_ICAL,
         `PAB_CMD_DPLUS_A, `PAB_CMD_DPLUS_B, `PAB_CMD_OCL, `PAB_CMD_UCL,
         `PAB_CMD_OVL, `PAB_CMD_UVL, `PAB_CMD_CONFIG, `PAB_CMD_RISE,
         `PAB_CMD_DAC};
      int ts [14] = '{TR, TE, TS, TC, TC, TM, TM, TM, TM, TM, TM, TM, TM,
         TM};
      for (int i = 0; i < 14; i++) begin
         v0 = valid_cnt;
         send(own, (i < 3) ? 1 : 3, cs[i], aa, ca);
         check(ca, 1'b1);
         check(16'(valid_cnt - v0), 16'h0001);
         check(cmd_code, cs[i]);
         busy_len(len);
         check(len >= ts[i] - 1 && len <= ts[i] + 6, 1'b1);
         cyc(4); // next command only once not busy
      end
   endtask
   task automatic t_refuse();
      logic aa, ca;
      logic [7:0] d;
      int len;
      send(own, 1, `PAB_CMD_RESTORE, aa, ca);
      cyc(10);
      check({busy, status[`PAB_STAT_NOTBUSY]}, 2'b10);
      send(own, 3, `PAB_CMD_OCL, aa, ca);
      check({aa, ca}, 2'b10);
      cyc(8);
      check({alert_n, fault}, 2'b01);
      check(cmd_code, `PAB_CMD_RESTORE);
      rd_status(d, ca);
      check({ca, d[6]}, 2'b10);
      busy_len(len);
      check({status[6], fault}, 2'b11);
      rd_status(d, ca);
      check({ca, d[6], fault}, 3'b111);
      pulse(1);
      check({alert_n, fault}, 2'b10);
      pulse(2);
      busy_len(len);
      check(len >= TS - 5 && len <= TS + 6, 1'b1);
   endtask
   task automatic t_clear();
      logic aa, ca;
      int len;
      send(own, 1, `PAB_CMD_CLEAR, aa, ca);
      check(ca, 1'b1);
      cyc(8);
      check({pend, busy}, 2'b10);
      send(own, 3, `PAB_CMD_OVL, aa, ca);
      check(ca, 1'b1);
      len = 0;
      while (pend === 1'b1 && len < TF) begin
         @(posedge clk);
         len++;
      end
      check(pend, 1'b0);
      busy_len(len);
      long_to <= 1'b1;
      cyc(4);
      check(long_o, 1'b1);
   endtask
   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0;
      base_we = 1'b0;
      long_to = 1'b0;
      flt_clr = 1'b0;
      log_ev = 1'b0;
      sel_lo = 2'b00;
      sel_hi = 2'b00;
      base = 7'h00;
      own = 7'h5c;
      fork
         host_u.idle_clk(4);
         cyc(12);
      join
      check({status, alert_n, busy}, 10'h102);
      rst_n <= 1'b1;
      cyc(6);
      t_addr();
      t_busy();
      t_refuse();
      t_clear();
      finish_test();
   end
   initial begin
      #1000000;
      err_count++;
      finish_test();
   end
endmodule
